// ### hdl/sio_pkg.sv
// constants and types for the serial i/o port
//
// Notes on behaviour
// (RQ1) firmware starts mode 0 reception: mode bits 00, receive-done clear, receive enable set
// (RQ2) a control register write takes effect at S6P2 of a peripheral cycle
// (RQ3) mode 0 receive: clock output falls at S3P1 of second cycle after write
// (RQ4) mode 0 receive: data pin sampled at S5P2, then shifted in
// (RQ5) mode 0 shifts once per cycle at S6P2; receive-done rises at S1P1 after eight
// (RQ6) control bit 7 is framing error when frame-error select set, else mode bit 0
// (RQ7) invalid stop bit sets framing error; only a firmware write clears it
// (RQ8) mode bits 00, 01, 10, 11 select modes 0, 1, 2, 3
// (RQ9) control bit 5 enables multiprocessor frames and address recognition
// (RQ10) control bit 4 enables reception when set
// (RQ11) control bit 3 is the ninth transmitted bit in modes 2 and 3
// (RQ12) control bit 2 takes stop bit in mode 1, ninth bit in modes 2, 3
// (RQ13) transmit-done flag, bit 1, set after last data bit; firmware clears it
// (RQ14) receive-done flag, bit 0, set after last data bit received; firmware clears it
// (RQ15) mode 1 is full duplex: transmit and receive at the same time
// (RQ16) mode 1 frame: start, eight data, stop; stop goes to received ninth bit
// (RQ17) modes 2 and 3 frame: start, eight data lsb first, ninth bit, stop
// (RQ18) mode 2 bit rate is core clock over 16 or over 32
// (RQ19) modes 1 and 3 bit rate comes from timer 1 or timer 2 overflow
// (RQ20) a serial buffer write starts transmission at S6P2
// (RQ21) asynchronous reception starts on a falling edge of the input pin
// (RQ22) frame-error select in power control enables stop bit checking
// (RQ23) serial buffer reads the received byte; writes load the transmit buffer
package sio_pkg;
  localparam logic [7:0] ADDR_POWER_CONTROL = 8'h87;
  localparam logic [7:0] ADDR_SERIAL_CONTROL = 8'h98;
  localparam logic [7:0] ADDR_SERIAL_BUFFER = 8'h99;
  localparam logic [7:0] ADDR_SLAVE_ADDR = 8'ha9;
  localparam logic [7:0] ADDR_SLAVE_MASK = 8'hb9;
  localparam logic [7:0] RST_SERIAL_CONTROL = 8'h00;
  localparam logic [7:0] RST_POWER_CONTROL = 8'h00;
  localparam logic [7:0] RST_SLAVE = 8'h00;
  localparam int PWR_BAUD_FAST = 7;
  localparam int PWR_FE_SEL = 6;
  localparam int PWR_TMR2_SEL = 0;
  localparam logic [1:0] MODE_SYNC = 2'h0;
  localparam logic [1:0] MODE_1 = 2'h1;
  localparam logic [1:0] MODE_2 = 2'h2;
  // phase index within a peripheral cycle, one clock per phase
  localparam logic [3:0] PH_S1P1 = 4'h0;
  localparam logic [3:0] PH_S3P1 = 4'h4;
  localparam logic [3:0] PH_S5P2 = 4'h9;
  localparam logic [3:0] PH_S6P1 = 4'ha;
  localparam logic [3:0] PH_S6P2 = 4'hb;
  localparam logic [3:0] M0_CLK_FIRST = 4'h2;
  localparam logic [3:0] M0_TX_LAST = 4'h8;
  localparam logic [3:0] M0_LAST = 4'h9;
  localparam logic [3:0] STOP_IDX_M1 = 4'h9;
  localparam logic [3:0] STOP_IDX_M23 = 4'ha;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } sio_bus_req_t;
  typedef struct packed {
    logic mode_select_bit0;
    logic mode_select_bit1;
    logic multiproc_address_enable;
    logic rx_enable;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
  } sio_ctl_t;
  typedef enum logic [1:0] {M0_IDLE, M0_TX, M0_RX} sio_m0_st_t;
  typedef enum logic {ATX_IDLE, ATX_RUN} sio_atx_st_t;
  typedef enum logic {ARX_IDLE, ARX_RUN} sio_arx_st_t;
endpackage

// ### hdl/sio_uart.sv
// serial i/o port: control register, mode 0 shifter, asynchronous transmitter and receiver
//
// The implementer's own choice: the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sio_uart #(
  parameter int OVS = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sio_pkg::sio_bus_req_t bus_i,
  output logic [7:0] rdata_o,
  input wire logic rxd_i,
  output logic rxd_o,
  output logic rxd_oe_o,
  output logic txd_o,
  input wire logic timer1_ovf_i,
  input wire logic timer2_ovf_i
);
  import sio_pkg::*;
  localparam logic [7:0] TICK_LAST = 8'(OVS - 1);
  localparam logic [7:0] TICK_MID = 8'(OVS / 2 - 1);

  sio_ctl_t ctl_r, ctl_nxt;
  logic fe_r, fe_nxt, ctl_pend_r, ctl_pend_nxt, buf_pend_r, buf_pend_nxt, half_r, half_nxt;
  logic [7:0] ctl_wd_r, ctl_wd_nxt, pwr_r, pwr_nxt, saddr_r, saddr_nxt, smask_r, smask_nxt;
  logic [7:0] rxbuf_r, rxbuf_nxt, txbuf_r, txbuf_nxt, rdata_r, rdata_nxt;
  logic [3:0] ph_r, ph_nxt;
  logic s6p2, ctl_apply, buf_apply, fe_sel, baud_tick, w_mode_bit0;
  logic [1:0] mode;
  logic m0_tx_done, m0_rx_done, atx_done, arx_done, arx_stop_bad, arx_ninth;
  logic [7:0] m0_rx_byte, arx_byte;

  assign s6p2 = (ph_r == PH_S6P2);
  assign ctl_apply = ctl_pend_r & s6p2;
  assign buf_apply = buf_pend_r & s6p2;
  assign fe_sel = pwr_r[PWR_FE_SEL];
  assign mode = {ctl_r.mode_select_bit0, ctl_r.mode_select_bit1};
  assign w_mode_bit0 = fe_sel ? ctl_r.mode_select_bit0 : ctl_wd_r[7];

  // modes 1 and 3 follow a timer overflow, mode 2 the core clock over 16 or 32
  always_comb begin
    if (mode == MODE_2) begin
      baud_tick = pwr_r[PWR_BAUD_FAST] | half_r; // [RQ18]
    end else begin
      baud_tick = pwr_r[PWR_TMR2_SEL] ? timer2_ovf_i : timer1_ovf_i; // [RQ19]
    end
  end

  // register file, phase counter and flag updates
  always_comb begin
    ph_nxt = (ph_r == PH_S6P2) ? PH_S1P1 : 4'(ph_r + 4'h1);
    half_nxt = ~half_r;
    ctl_nxt = ctl_r;
    fe_nxt = fe_r;
    ctl_pend_nxt = ctl_pend_r & ~s6p2;
    buf_pend_nxt = buf_pend_r & ~s6p2;
    ctl_wd_nxt = ctl_wd_r;
    pwr_nxt = pwr_r;
    saddr_nxt = saddr_r;
    smask_nxt = smask_r;
    rxbuf_nxt = rxbuf_r;
    txbuf_nxt = txbuf_r;
    rdata_nxt = 8'h00;
    if (ctl_apply) begin
      ctl_nxt = sio_ctl_t'(ctl_wd_r); // [RQ2]
      if (fe_sel) begin
        ctl_nxt.mode_select_bit0 = ctl_r.mode_select_bit0; // [RQ6]
        fe_nxt = ctl_wd_r[7]; // [RQ7]
      end
    end
    if (bus_i.wr) begin
      unique case (bus_i.addr)
        ADDR_SERIAL_CONTROL: begin
          ctl_pend_nxt = 1'b1;
          ctl_wd_nxt = bus_i.wdata;
        end
        ADDR_SERIAL_BUFFER: begin
          buf_pend_nxt = 1'b1; // [RQ20]
          txbuf_nxt = bus_i.wdata; // [RQ23]
        end
        ADDR_POWER_CONTROL: pwr_nxt = bus_i.wdata; // [RQ22]
        ADDR_SLAVE_ADDR: saddr_nxt = bus_i.wdata;
        ADDR_SLAVE_MASK: smask_nxt = bus_i.wdata;
        default: ;
      endcase
    end
    if (bus_i.rd) begin
      unique case (bus_i.addr)
        ADDR_SERIAL_CONTROL: rdata_nxt = {fe_sel ? fe_r : ctl_r.mode_select_bit0, 7'(ctl_r)}; // [RQ6]
        ADDR_SERIAL_BUFFER: rdata_nxt = rxbuf_r; // [RQ23]
        ADDR_POWER_CONTROL: rdata_nxt = pwr_r;
        ADDR_SLAVE_ADDR: rdata_nxt = saddr_r;
        ADDR_SLAVE_MASK: rdata_nxt = smask_r;
        default: rdata_nxt = 8'h00;
      endcase
    end
    // hardware sets after the firmware write so a same-cycle event is kept
    if (m0_tx_done | atx_done) ctl_nxt.tx_done_flag = 1'b1; // [RQ13]
    if (m0_rx_done) begin
      ctl_nxt.rx_done_flag = 1'b1; // [RQ14]
      rxbuf_nxt = m0_rx_byte;
    end
    if (arx_done) begin
      ctl_nxt.rx_done_flag = 1'b1; // [RQ14]
      ctl_nxt.rx_ninth_bit = arx_ninth; // [RQ12]
      rxbuf_nxt = arx_byte;
    end
    if (arx_stop_bad & fe_sel) fe_nxt = 1'b1; // [RQ7] [RQ22]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ph_r <= PH_S1P1;
      half_r <= 1'b0;
      ctl_r <= sio_ctl_t'(RST_SERIAL_CONTROL);
      fe_r <= 1'b0;
      ctl_pend_r <= 1'b0;
      buf_pend_r <= 1'b0;
      ctl_wd_r <= RST_SERIAL_CONTROL;
      pwr_r <= RST_POWER_CONTROL;
      saddr_r <= RST_SLAVE;
      smask_r <= RST_SLAVE;
      rxbuf_r <= 8'h00;
      txbuf_r <= 8'h00;
      rdata_r <= 8'h00;
    end else begin
      ph_r <= ph_nxt;
      half_r <= half_nxt;
      ctl_r <= ctl_nxt;
      fe_r <= fe_nxt;
      ctl_pend_r <= ctl_pend_nxt;
      buf_pend_r <= buf_pend_nxt;
      ctl_wd_r <= ctl_wd_nxt;
      pwr_r <= pwr_nxt;
      saddr_r <= saddr_nxt;
      smask_r <= smask_nxt;
      rxbuf_r <= rxbuf_nxt;
      txbuf_r <= txbuf_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  // mode 0 synchronous shifter: clock on the transmit pin, data on the two-way pin
  sio_m0_st_t m0_st_r, m0_st_nxt;
  logic [3:0] m0_cyc_r, m0_cyc_nxt;
  logic [7:0] m0_sh_r, m0_sh_nxt;
  logic m0_samp_r, m0_samp_nxt, dout_r, dout_nxt, oe_r, oe_nxt, m0_clk_nxt;

  always_comb begin
    m0_st_nxt = m0_st_r;
    m0_cyc_nxt = m0_cyc_r;
    m0_sh_nxt = m0_sh_r;
    m0_samp_nxt = m0_samp_r;
    dout_nxt = dout_r;
    oe_nxt = oe_r;
    m0_tx_done = 1'b0;
    m0_rx_done = 1'b0;
    m0_rx_byte = {m0_samp_r, m0_sh_r[7:1]};
    unique case (m0_st_r)
      M0_IDLE: begin
        dout_nxt = 1'b1;
        oe_nxt = 1'b0;
        if (buf_apply && mode == MODE_SYNC) begin
          m0_st_nxt = M0_TX;
          m0_cyc_nxt = 4'h1;
          m0_sh_nxt = txbuf_r;
          oe_nxt = 1'b1;
        end else if (ctl_apply && {w_mode_bit0, ctl_wd_r[6]} == MODE_SYNC && ctl_wd_r[4] && !ctl_wd_r[0]) begin
          m0_st_nxt = M0_RX; // [RQ1] [RQ8]
          m0_cyc_nxt = 4'h1;
        end
      end
      M0_TX, M0_RX: begin
        if (s6p2) begin
          if (m0_st_r == M0_TX && m0_cyc_r <= M0_TX_LAST) begin
            dout_nxt = m0_sh_r[0];
            m0_sh_nxt = {1'b0, m0_sh_r[7:1]};
          end
          if (m0_st_r == M0_RX && m0_cyc_r >= M0_CLK_FIRST) begin
            m0_sh_nxt = m0_rx_byte; // [RQ5]
          end
          if (m0_cyc_r == M0_LAST) begin
            m0_st_nxt = M0_IDLE;
            dout_nxt = 1'b1;
            oe_nxt = 1'b0;
            m0_tx_done = (m0_st_r == M0_TX);
            m0_rx_done = (m0_st_r == M0_RX); // [RQ5]
          end else begin
            m0_cyc_nxt = 4'(m0_cyc_r + 4'h1);
          end
        end else if (ph_r == PH_S5P2 && m0_st_r == M0_RX) begin
          m0_samp_nxt = rxd_i; // [RQ4]
        end
      end
    endcase
    // clock low from S3P1 to S6P1 in cycles two to nine
    m0_clk_nxt = !(m0_st_nxt != M0_IDLE && m0_cyc_nxt >= M0_CLK_FIRST
                   && ph_nxt >= PH_S3P1 && ph_nxt < PH_S6P1); // [RQ3]
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      m0_st_r <= M0_IDLE;
      m0_cyc_r <= 4'h0;
      m0_sh_r <= 8'h00;
      m0_samp_r <= 1'b0;
      dout_r <= 1'b1;
      oe_r <= 1'b0;
    end else begin
      m0_st_r <= m0_st_nxt;
      m0_cyc_r <= m0_cyc_nxt;
      m0_sh_r <= m0_sh_nxt;
      m0_samp_r <= m0_samp_nxt;
      dout_r <= dout_nxt;
      oe_r <= oe_nxt;
    end
  end

  // asynchronous transmitter, independent of the receiver
  sio_atx_st_t atx_st_r, atx_st_nxt;
  logic [10:0] atx_sh_r, atx_sh_nxt;
  logic [7:0] atx_tick_r, atx_tick_nxt;
  logic [3:0] atx_bit_r, atx_bit_nxt, atx_stop;
  logic txd_r, txd_nxt;

  always_comb begin
    atx_st_nxt = atx_st_r;
    atx_sh_nxt = atx_sh_r;
    atx_tick_nxt = atx_tick_r;
    atx_bit_nxt = atx_bit_r;
    atx_done = 1'b0;
    atx_stop = (mode == MODE_1) ? STOP_IDX_M1 : STOP_IDX_M23; // [RQ16] [RQ17]
    unique case (atx_st_r)
      ATX_IDLE: begin
        if (buf_apply && mode != MODE_SYNC) begin
          atx_st_nxt = ATX_RUN; // [RQ20] [RQ15]
          atx_sh_nxt = {1'b1, (mode == MODE_1) ? 1'b1 : ctl_r.tx_ninth_bit, txbuf_r, 1'b0}; // [RQ11] [RQ17]
          atx_tick_nxt = 8'h00;
          atx_bit_nxt = 4'h0;
        end
      end
      ATX_RUN: begin
        if (baud_tick) begin
          if (atx_tick_r == TICK_LAST) begin
            atx_tick_nxt = 8'h00;
            atx_sh_nxt = {1'b1, atx_sh_r[10:1]};
            atx_bit_nxt = 4'(atx_bit_r + 4'h1);
            atx_done = (atx_bit_nxt == atx_stop); // [RQ13]
            if (atx_bit_r == atx_stop) atx_st_nxt = ATX_IDLE;
          end else begin
            atx_tick_nxt = 8'(atx_tick_r + 8'h01);
          end
        end
      end
    endcase
    if (mode == MODE_SYNC) begin
      txd_nxt = m0_clk_nxt;
    end else begin
      txd_nxt = (atx_st_nxt == ATX_RUN) ? atx_sh_nxt[0] : 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      atx_st_r <= ATX_IDLE;
      atx_sh_r <= 11'h7ff;
      atx_tick_r <= 8'h00;
      atx_bit_r <= 4'h0;
      txd_r <= 1'b1;
    end else begin
      atx_st_r <= atx_st_nxt;
      atx_sh_r <= atx_sh_nxt;
      atx_tick_r <= atx_tick_nxt;
      atx_bit_r <= atx_bit_nxt;
      txd_r <= txd_nxt;
    end
  end

  // asynchronous receiver with address recognition
  sio_arx_st_t arx_st_r, arx_st_nxt;
  logic [9:0] arx_sh_r, arx_sh_nxt;
  logic [7:0] arx_tick_r, arx_tick_nxt, bcast;
  logic [3:0] arx_bit_r, arx_bit_nxt;
  logic arx_prev_r, arx_prev_nxt, arx_stop, addr_hit;

  always_comb begin
    arx_st_nxt = arx_st_r;
    arx_sh_nxt = arx_sh_r;
    arx_tick_nxt = arx_tick_r;
    arx_bit_nxt = arx_bit_r;
    arx_prev_nxt = rxd_i;
    arx_done = 1'b0;
    arx_stop_bad = 1'b0;
    arx_stop = arx_sh_r[9];
    arx_byte = (mode == MODE_1) ? arx_sh_r[8:1] : arx_sh_r[7:0];
    arx_ninth = (mode == MODE_1) ? arx_stop : arx_sh_r[8]; // [RQ12] [RQ16]
    bcast = saddr_r | smask_r;
    addr_hit = (((arx_byte ^ saddr_r) & smask_r) == 8'h00) || ((arx_byte & bcast) == bcast);
    unique case (arx_st_r)
      ARX_IDLE: begin
        if (mode != MODE_SYNC && ctl_r.rx_enable && arx_prev_r && !rxd_i) begin
          arx_st_nxt = ARX_RUN; // [RQ21] [RQ10]
          arx_tick_nxt = 8'h00;
          arx_bit_nxt = 4'h0;
        end
      end
      ARX_RUN: begin
        if (baud_tick) begin
          arx_tick_nxt = (arx_tick_r == TICK_LAST) ? 8'h00 : 8'(arx_tick_r + 8'h01);
          if (arx_tick_r == TICK_MID) begin
            arx_bit_nxt = 4'(arx_bit_r + 4'h1);
            if (arx_bit_r == 4'h0) begin
              if (rxd_i) arx_st_nxt = ARX_IDLE;
            end else begin
              arx_sh_nxt = {rxd_i, arx_sh_r[9:1]};
            end
          end
        end
        // frame complete once the stop bit has been shifted in
        if (arx_bit_r == ((mode == MODE_1) ? 4'ha : 4'hb)) begin
          arx_st_nxt = ARX_IDLE;
          arx_stop_bad = ~arx_stop; // [RQ7]
          arx_done = !ctl_r.multiproc_address_enable
                     || (arx_ninth && addr_hit && (mode != MODE_1 || arx_stop)); // [RQ9]
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      arx_st_r <= ARX_IDLE;
      arx_sh_r <= 10'h000;
      arx_tick_r <= 8'h00;
      arx_bit_r <= 4'h0;
      arx_prev_r <= 1'b1;
    end else begin
      arx_st_r <= arx_st_nxt;
      arx_sh_r <= arx_sh_nxt;
      arx_tick_r <= arx_tick_nxt;
      arx_bit_r <= arx_bit_nxt;
      arx_prev_r <= arx_prev_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign txd_o = txd_r;
  assign rxd_o = dout_r;
  assign rxd_oe_o = oe_r;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  property p_ctl_at_s6p2;
    $changed(ctl_r.rx_enable) |-> $past(ph_r) == PH_S6P2;
  endproperty
  a_ctl_at_s6p2: assert property (p_ctl_at_s6p2) else $error("control write applied off S6P2"); // [RQ2]

  property p_m0_clk_s3p1;
    mode == MODE_SYNC && $fell(txd_o) |-> ph_r == PH_S3P1 ##6 $rose(txd_o);
  endproperty
  a_m0_clk_s3p1: assert property (p_m0_clk_s3p1) else $error("mode 0 clock pulse misplaced"); // [RQ3]

  property p_m0_first_pulse;
    m0_st_r == M0_IDLE && m0_st_nxt == M0_RX |=> txd_o [*8] ##1 txd_o [*8] ##1 !txd_o;
  endproperty
  a_m0_first_pulse: assert property (p_m0_first_pulse) else $error("first clock not in second cycle"); // [RQ3]

  property p_m0_rx_done_s1p1;
    $rose(ctl_r.rx_done_flag) && mode == MODE_SYNC |-> ph_r == PH_S1P1 && $past(m0_cyc_r) == M0_LAST;
  endproperty
  a_m0_rx_done_s1p1: assert property (p_m0_rx_done_s1p1) else $error("mode 0 receive-done mistimed"); // [RQ5]

  property p_fe_sticky;
    fe_r && !ctl_apply |=> fe_r;
  endproperty
  a_fe_sticky: assert property (p_fe_sticky) else $error("framing error cleared by hardware"); // [RQ7]

  property p_tx_flag_clear;
    $fell(ctl_r.tx_done_flag) |-> $past(ctl_apply);
  endproperty
  a_tx_flag_clear: assert property (p_tx_flag_clear) else $error("transmit-done cleared without write"); // [RQ13]

  property p_rx_flag_clear;
    $fell(ctl_r.rx_done_flag) |-> $past(ctl_apply);
  endproperty
  a_rx_flag_clear: assert property (p_rx_flag_clear) else $error("receive-done cleared without write"); // [RQ14]

  property p_rx_needs_enable;
    arx_st_r == ARX_IDLE && arx_st_nxt == ARX_RUN |-> ctl_r.rx_enable && $past(rxd_i, 1) && !rxd_i;
  endproperty
  a_rx_needs_enable: assert property (p_rx_needs_enable) else $error("receiver started without enable"); // [RQ21]

  property p_tx_start;
    buf_apply && mode != MODE_SYNC && atx_st_r == ATX_IDLE |=> atx_st_r == ATX_RUN && !txd_o;
  endproperty
  a_tx_start: assert property (p_tx_start) else $error("buffer write did not start frame"); // [RQ20]

  c_m0_rx: cover property (m0_rx_done);
  c_m0_tx: cover property (m0_tx_done);
  c_arx_done: cover property (arx_done);
  c_fe_set: cover property ($rose(fe_r));
endmodule
`default_nettype wire

// ### dv/sio_peer.sv
// far-side model: mode 0 shift register and asynchronous serial peer
`timescale 1ns/1ps
`default_nettype none
module sio_peer (
  input wire logic clk_i,
  input wire logic txd_i,
  input wire logic line_i,
  input wire logic oe_i,
  input wire logic m0_i,
  input wire logic nine_i,
  input wire logic [31:0] bclk_i,
  output logic drv_o,
  output logic vld_o,
  output logic [9:0] got_o
);
  logic [7:0] sh = 8'hff;
  logic [7:0] cap = 8'h00;
  logic [9:0] fr = '0;
  logic a_drv = 1'b1;
  int n0 = 0;
  initial begin
    vld_o = 1'b0;
    got_o = '0;
  end
  // async line idles high: a_drv is driven to 1 between frames
  assign drv_o = m0_i ? sh[0] : a_drv;
  task automatic m0_load(input logic [7:0] d);
    sh = d;
    n0 = 0;
  endtask
  task automatic emit(input logic [9:0] v);
    got_o <= v;
    vld_o <= 1'b1;
    @(posedge clk_i);
    vld_o <= 1'b0;
  endtask
  // shift on the rising clock edge; the emptied slot refills with a changing bit
  always @(posedge txd_i) begin
    if (m0_i) begin
      sh = {~sh[0], sh[7:1]};
      if (oe_i) begin
        cap = {line_i, cap[7:1]};
        n0++;
        if (n0 == 8) emit({2'b00, cap});
      end
    end
  end
  // frame decode sampled at mid bit
  always begin
    @(negedge txd_i);
    if (!m0_i) begin
      repeat (bclk_i / 2) @(posedge clk_i);
      fr = '0;
      if (txd_i === 1'b0) begin
        for (int k = 0; k < 10; k++) begin
          if (k != 8 || nine_i) begin
            repeat (bclk_i) @(posedge clk_i);
            fr[k] = txd_i;
          end
        end
        emit(fr);
      end
    end
  end
  task automatic send(input logic [7:0] d, input logic n, input logic stp);
    logic [10:0] f;
    f = {stp, n, d, 1'b0};
    for (int k = 0; k < 11; k++) begin
      if (k != 9 || nine_i) begin
        a_drv <= f[k];
        repeat (bclk_i) @(posedge clk_i);
      end
    end
    a_drv <= 1'b1;
    repeat (bclk_i) @(posedge clk_i);
  endtask
endmodule
`default_nettype wire

// ### dv/tb_sio_uart.sv
// self-checking bench for the serial i/o port
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin comparisons++; if ((e) !== (g)) begin n_fail++; $display("MISMATCH %s exp=%h got=%h", nm, e, g); end end
module tb_sio_uart;
  import sio_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  sio_bus_req_t bus = '0;
  logic [7:0] rdata_o;
  logic rxd_o, rxd_oe_o, txd_o, line, drv, vld, n;
  logic t1 = 1'b0, t2 = 1'b0, m0 = 1'b0, nine = 1'b0, rd_d = 1'b0;
  logic [9:0] got, ef;
  logic [15:0] ent;
  logic [7:0] d;
  logic [15:0] exp_rd[$];
  logic [9:0] exp_tx[$];
  int bclk = 16, tcnt = 0, ph = 0, n_fail = 0, comparisons = 0;
  logic [7:0] pc_t[5] = '{8'h80, 8'h80, 8'h00, 8'h00, 8'h01};
  logic [7:0] ctl_t[5] = '{8'h90, 8'h98, 8'h98, 8'h50, 8'hd8};
  int bc_t[5] = '{16, 16, 32, 32, 48};
  assign line = rxd_oe_o ? rxd_o : drv;
  sio_uart #(.OVS(16)) u_dut (.clk_i(clk_i), .rst_i(rst_i), .bus_i(bus), .rdata_o(rdata_o), .rxd_i(line),
    .rxd_o(rxd_o), .rxd_oe_o(rxd_oe_o), .txd_o(txd_o), .timer1_ovf_i(t1), .timer2_ovf_i(t2));
  sio_peer u_peer (.clk_i(clk_i), .txd_i(txd_o), .line_i(line), .oe_i(rxd_oe_o), .m0_i(m0), .nine_i(nine),
    .bclk_i(bclk), .drv_o(drv), .vld_o(vld), .got_o(got));
  initial begin
    forever #5 clk_i = ~clk_i;
  end
  task automatic stop_test();
    if (n_fail == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic sync(input int p);
    do @(posedge clk_i); while (ph != p);
  endtask
  task automatic acc(input logic [7:0] a, input logic [7:0] wd, input logic w);
    bus <= '{addr: a, wdata: wd, wr: w, rd: !w};
    @(posedge clk_i);
    bus <= '0;
    @(posedge clk_i);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] wd);
    acc(a, wd, 1'b1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m = 8'hff);
    exp_rd.push_back({m, e & m});
    acc(a, 8'h00, 1'b0);
  endtask
  // timer overflows at different rates so a wrong source shows as a wrong bit time
  always @(posedge clk_i) begin
    tcnt <= tcnt + 1;
    t1 <= (tcnt % 2 == 0);
    t2 <= (tcnt % 3 == 0);
    ph <= (rst_i || ph == 11) ? 0 : ph + 1;
    rd_d <= bus.rd;
    if (rd_d) begin
      ent = exp_rd.pop_front();
      `CHK("rdata", ent[7:0], rdata_o & ent[15:8])
    end else if (!rst_i) `CHK("rdata_idle", 8'h00, rdata_o)
    if (vld) begin
      ef = exp_tx.pop_front();
      `CHK("frame", ef, got)
    end
    if (tcnt == 20000) begin
      n_fail++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'hee3e));
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_SERIAL_CONTROL, RST_SERIAL_CONTROL);
    rd(ADDR_POWER_CONTROL, RST_POWER_CONTROL);
    rd(ADDR_SLAVE_ADDR, RST_SLAVE);
    rd(ADDR_SLAVE_MASK, RST_SLAVE);
    wr(8'h55, 8'hff);
    rd(8'h55, 8'h00);
    sync(0);
    wr(ADDR_SERIAL_CONTROL, 8'h40);
    rd(ADDR_SERIAL_CONTROL, 8'h00);
    sync(11);
    rd(ADDR_SERIAL_CONTROL, 8'h40);
    d = $urandom;
    m0 = 1'b1;
    u_peer.m0_load(d);
    sync(0);
    wr(ADDR_SERIAL_CONTROL, 8'h10);
    repeat (100) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h00, 8'h01);
    repeat (30) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h11);
    rd(ADDR_SERIAL_BUFFER, d);
    wr(ADDR_SERIAL_CONTROL, 8'h00);
    repeat (13) @(posedge clk_i);
    d = $urandom;
    exp_tx.push_back({2'b00, d});
    wr(ADDR_SERIAL_BUFFER, d);
    repeat (140) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h02);
    wr(ADDR_SERIAL_CONTROL, 8'h00);
    m0 = 1'b0;
    repeat (13) @(posedge clk_i);
    for (int i = 0; i < 5; i++) begin
      wr(ADDR_POWER_CONTROL, pc_t[i]);
      wr(ADDR_SERIAL_CONTROL, ctl_t[i]);
      bclk = bc_t[i];
      nine = ctl_t[i][7];
      repeat (13) @(posedge clk_i);
      d = $urandom;
      n = $urandom;
      exp_tx.push_back({1'b1, ctl_t[i][7] & ctl_t[i][3], d});
      fork
        wr(ADDR_SERIAL_BUFFER, d);
        u_peer.send(d ^ 8'h5a, n, 1'b1);
      join
      repeat (bclk + 30) @(posedge clk_i);
      rd(ADDR_SERIAL_CONTROL, ctl_t[i] & 8'hf8 | {5'h00, nine ? n : 1'b1, 2'b11});
      rd(ADDR_SERIAL_BUFFER, d ^ 8'h5a);
      wr(ADDR_SERIAL_CONTROL, ctl_t[i]);
      repeat (13) @(posedge clk_i);
    end
    wr(ADDR_POWER_CONTROL, 8'h80);
    wr(ADDR_SERIAL_CONTROL, 8'h90);
    bclk = 16;
    nine = 1'b1;
    repeat (13) @(posedge clk_i);
    wr(ADDR_POWER_CONTROL, 8'hc0);
    rd(ADDR_SERIAL_CONTROL, 8'h10);
    u_peer.send(8'h3c, 1'b1, 1'b0);
    repeat (20) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h80, 8'h80);
    // no control write here: with select set it would rewrite the error flag itself
    repeat (13) @(posedge clk_i);
    u_peer.send(8'hc3, 1'b1, 1'b1);
    repeat (20) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h80, 8'h80);
    wr(ADDR_SERIAL_CONTROL, 8'h10);
    repeat (13) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h00, 8'h80);
    wr(ADDR_POWER_CONTROL, 8'h80);
    rd(ADDR_SERIAL_CONTROL, 8'h80, 8'h80);
    wr(ADDR_SLAVE_ADDR, 8'h56);
    wr(ADDR_SLAVE_MASK, 8'hfc);
    wr(ADDR_SERIAL_CONTROL, 8'hb0);
    repeat (13) @(posedge clk_i);
    u_peer.send(8'h57, 1'b0, 1'b1);
    repeat (20) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h00, 8'h01);
    u_peer.send(8'h12, 1'b1, 1'b1);
    repeat (20) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h00, 8'h01);
    u_peer.send(8'h57, 1'b1, 1'b1);
    repeat (20) @(posedge clk_i);
    rd(ADDR_SERIAL_CONTROL, 8'h05, 8'h05);
    rd(ADDR_SERIAL_BUFFER, 8'h57);
    `CHK("frames_left", 0, exp_tx.size())
    stop_test();
  end
endmodule
`default_nettype wire
